// File: verification/sys_apb_mst.sv
module sys_apb_mst (
  // Clock
  input  wire logic        pclk,
  // Requests
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  // Answers
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
  end

  // One transfer; the byte address is four times the register index
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [7:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= wd;
    pstrb   <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    // Hold everything until the answer is sampled; only the watchdog ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data shows no stale value
    pwdata  <= ~pwdata;
  endtask : xfer
endmodule : sys_apb_mst

// File: verification/sys_tmr_props.sv
module sys_tmr_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Requests
  input wire logic        first_irq,
  input wire logic        second_irq,
  input wire logic        third_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic       wr_go;
  logic       wr2;
  logic       wr34;
  logic [7:0] en_q;

  // Completed writes to the two control bytes
  assign wr_go = psel && penable && pready && pwrite && pstrb[0];
  assign wr2   = wr_go && (paddr == {2'h0, sys_tmr_pkg::IDX_FT_CON, 2'h0});
  assign wr34  = wr_go && (paddr == {2'h0, sys_tmr_pkg::IDX_T34_CON, 2'h0});

  // Shadow of the enable bits; software is their only writer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_q <= 8'h00;
    else if (wr34) en_q <= pwdata[7:0];
  end

  sequence s_setup;
    psel && !penable;
  endsequence
  // No software write now or one edge ago, so a set flag cannot drop
  sequence s_quiet2;
    !wr2 && !$past(wr2);
  endsequence
  sequence s_quiet34;
    !wr34 && !$past(wr34);
  endsequence

  a_ready_after_setup: assert property (s_setup |=> pready && penable)
    else $error("no answer after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("answer held too long");
  a_ready_in_access: assert property (pready |-> psel && $past(psel && !penable))
    else $error("answer outside access");
  a_err_unmapped: assert property (s_setup ##0 paddr == 12'h324 |=> pslverr)
    else $error("unmapped index accepted");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_first_irq_sticky: assert property (first_irq ##0 s_quiet2 |=> first_irq)
    else $error("first flag dropped by hardware");
  a_second_irq_sticky: assert property (second_irq ##0 s_quiet34 |=> second_irq)
    else $error("second flag dropped by hardware");
  a_second_irq_masked: assert property (!$past(en_q[0]) |-> !second_irq)
    else $error("second request not masked");
  a_third_irq_masked: assert property (!$past(en_q[4]) |-> !third_irq)
    else $error("third request not masked");
endmodule : sys_tmr_props

// File: verification/tb_sys_tmr_top.sv
module tb_sys_tmr_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk;
  logic        presetn;
  logic        pin;
  logic        osc;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        first_irq;
  logic        second_irq;
  logic        third_irq;
  logic        wake_request;
  logic [7:0]  rd_v;
  logic        err_v;
  int          error_cnt;
  int          cmp_count;

  // Only the slow source toggles; the other oscillator pins stay idle
  sys_tmr_top sys_tmr_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_trigger_pin(pin), .fast_internal_oscillator(1'b0),
    .crystal_oscillator(1'b0), .rtc_clock(1'b0), .slow_oscillator(osc),
    .first_irq(first_irq), .second_irq(second_irq), .third_irq(third_irq),
    .wake_request(wake_request)
  );
  sys_apb_mst sys_apb_mst_i (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic print_verdict();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    sys_apb_mst_i.xfer(1'b1, idx, {24'h0, d}, rd_v, err_v);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
    sys_apb_mst_i.xfer(1'b0, idx, 32'h0, rd_v, err_v);
    chk(rd_v, exp, what);
  endtask : rd

  // Poll a control byte; bounded so a dead timer shows up as a mismatch
  task automatic wait_flag(input logic [7:0] idx, input logic [7:0] mask);
    int n = 0;
    do begin
      sys_apb_mst_i.xfer(1'b0, idx, 32'h0, rd_v, err_v);
      n++;
    end while ((rd_v & mask) == 8'h00 && n < 40);
    chk(rd_v & mask, mask, "flag");
  endtask : wait_flag

  // One falling edge on the shared pin, long enough for the synchroniser
  task automatic fall();
    @(posedge pclk);
    pin <= 1'b0;
    repeat (6) @(posedge pclk);
    pin <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : fall

  task automatic t_reset();
    logic [7:0] idx [10] = '{8'hac, 8'had, 8'hae, 8'haf, 8'hc8, 8'hca, 8'hcb, 8'hcc,
                             8'hcd, 8'hcf};
    foreach (idx[i]) rd(idx[i], 8'h00, "reset value");
    sys_apb_mst_i.xfer(1'b1, 8'hc9, 32'h5a, rd_v, err_v);
    chk({7'h0, err_v}, 8'h01, "unmapped error");
  endtask : t_reset

  task automatic t_free(input int sh, input logic [7:0] lo);
    wr(lo + 8'h1, 8'hff);
    wr(lo, 8'hf0);
    rd(lo, 8'hf0, "live count");
    wr(8'hcf, 8'h03 << sh);
    wait_flag(8'hcf, 8'h08 << sh);
    chk({7'h0, (sh == 0) ? second_irq : third_irq}, 8'h01, "irq");
    rd(lo + 8'h1, 8'h00, "wrapped high");
    wr(8'hcf, 8'h01 << sh);
    wr(lo, 8'h55);
    repeat (10) @(posedge pclk);
    rd(lo, 8'h55, "stopped count");
    chk({7'h0, (sh == 0) ? second_irq : third_irq}, 8'h00, "irq cleared");
  endtask : t_free

  task automatic t_reload(input int sh, input logic [7:0] lo);
    wr(8'hcf, 8'h00);
    wr(lo + 8'h1, 8'hff);
    wr(lo, 8'hf0);
    wr(8'hcf, 8'h04 << sh);
    wr(lo + 8'h1, 8'h12);
    wr(lo, 8'h34);
    rd(lo, 8'hf0, "live kept");
    wr(8'hcf, 8'h06 << sh);
    wait_flag(8'hcf, 8'h08 << sh);
    rd(lo + 8'h1, 8'h12, "reloaded high");
    chk({7'h0, (sh == 0) ? second_irq : third_irq}, 8'h00, "masked irq");
    wr(8'hcf, 8'h00);
  endtask : t_reload

  task automatic t_ft_reload();
    wr(8'hcb, 8'h80);
    wr(8'hca, 8'h00);
    wr(8'hcd, 8'hff);
    wr(8'hcc, 8'hf0);
    wr(8'hc8, 8'h04);
    wait_flag(8'hc8, 8'h80);
    rd(8'hcd, 8'h80, "reloaded");
    chk({7'h0, first_irq}, 8'h01, "first irq");
    wr(8'hc8, 8'h00);
    wr(8'hcc, 8'h77);
    repeat (8) @(posedge pclk);
    rd(8'hcc, 8'h77, "stopped");
    rd(8'hc8, 8'h00, "cleared");
  endtask : t_ft_reload

  task automatic t_capture();
    wr(8'hcb, 8'h00);
    wr(8'hca, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'hcc, 8'h00);
    wr(8'hc8, 8'h0d);
    repeat (20) @(posedge pclk);
    fall();
    rd(8'hc8, 8'h4d, "edge flag");
    wr(8'hc8, 8'h00);
    rd(8'hcb, 8'h00, "capture high");
    sys_apb_mst_i.xfer(1'b0, 8'hca, 32'h0, rd_v, err_v);
    chk({7'h0, rd_v > 8'h10 && rd_v < 8'h40}, 8'h01, "capture low");
    wr(8'hca, 8'h00);
    wr(8'hc8, 8'h05);
    fall();
    rd(8'hca, 8'h00, "edge ignored");
    rd(8'hc8, 8'h05, "no edge flag");
    wr(8'hc8, 8'h00);
  endtask : t_capture

  task automatic t_count();
    wr(8'hcd, 8'h00);
    wr(8'hcc, 8'h00);
    wr(8'hc8, 8'h06);
    repeat (3) fall();
    wr(8'hc8, 8'h00);
    rd(8'hcc, 8'h03, "event count");
    // Enabled trigger in reload mode loads the reload pair into the count
    wr(8'hcb, 8'h80);
    wr(8'hc8, 8'h0e);
    fall();
    rd(8'hcd, 8'h80, "trigger reload");
    wr(8'hc8, 8'h00);
  endtask : t_count

  task automatic t_baud();
    logic [7:0] cfg [3] = '{8'h14, 8'h15, 8'h24};
    wr(8'hcb, 8'hff);
    wr(8'hca, 8'hf0);
    wr(8'hcd, 8'hff);
    wr(8'hcc, 8'hf0);
    foreach (cfg[i]) begin
      wr(8'hc8, cfg[i]);
      repeat (60) @(posedge pclk);
      rd(8'hc8, cfg[i], "baud flag");
      rd(8'hcd, 8'hff, "baud reload");
      chk({7'h0, first_irq}, 8'h00, "baud irq");
      wr(8'hc8, 8'h00);
    end
  endtask : t_baud

  // Wide timer on the slow source: four rising edges wrap it past all ones
  task automatic t_wide();
    sys_apb_mst_i.xfer(1'b1, 8'he1, 32'h00fffffe, rd_v, err_v);
    wr(8'he0, 8'h69);
    repeat (4) begin
      osc <= 1'b1;
      repeat (4) @(posedge pclk);
      osc <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    rd(8'he1, 8'h02, "wide wrap");
    rd(8'he0, 8'he9, "wide flag");
    chk({7'h0, wake_request}, 8'h01, "wake");
    wr(8'he0, 8'h00);
  endtask : t_wide

  // Watchdog: the whole sequence needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    presetn = 1'b0;
    pin = 1'b1;
    osc = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset();
    t_free(0, 8'hae);
    t_free(4, 8'hac);
    t_reload(0, 8'hae);
    t_reload(4, 8'hac);
    t_ft_reload();
    t_capture();
    t_count();
    t_baud();
    t_wide();
    print_verdict();
  end
endmodule : tb_sys_tmr_top

bind sys_tmr_top sys_tmr_props sys_tmr_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .first_irq(first_irq), .second_irq(second_irq), .third_irq(third_irq)
);

// File: verilog/sys_tmr_pkg.sv
package sys_tmr_pkg;

  // Register indices; the bus byte address is four times the index
  localparam logic [7:0] IDX_T4_LO   = 8'hac;
  localparam logic [7:0] IDX_T4_HI   = 8'had;
  localparam logic [7:0] IDX_T3_LO   = 8'hae;
  localparam logic [7:0] IDX_T3_HI   = 8'haf;
  localparam logic [7:0] IDX_FT_CON  = 8'hc8;
  localparam logic [7:0] IDX_FT_RLLO = 8'hca;
  localparam logic [7:0] IDX_FT_RLHI = 8'hcb;
  localparam logic [7:0] IDX_FT_LO   = 8'hcc;
  localparam logic [7:0] IDX_FT_HI   = 8'hcd;
  localparam logic [7:0] IDX_T34_CON = 8'hcf;
  localparam logic [7:0] IDX_T5_CON  = 8'he0;
  localparam logic [7:0] IDX_T5_CNT  = 8'he1;

  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_CNT  = 16'h0000;
  localparam logic [23:0] RST_T5   = 24'h000000;

  // Terminal counts: overflow is the wrap from all ones to zero
  localparam logic [15:0] MAX_CNT16 = 16'hffff;
  localparam logic [23:0] MAX_CNT24 = 24'hffffff;

  // Pin positions in the sampled input vector
  localparam int unsigned PIN_SHARED = 0;
  localparam int unsigned PIN_FAST   = 1;
  localparam int unsigned PIN_XTAL   = 2;
  localparam int unsigned PIN_RTC    = 3;
  localparam int unsigned PIN_SLOW   = 4;
  localparam int unsigned N_PINS     = 5;

  // Width of the bus address; its two low bits and two top bits must be zero
  localparam int unsigned ADDR_W = 12;

  // First timer control byte, bit 7 first
  typedef struct packed {
    logic first_timer_overflow_flag;
    logic trigger_edge_flag;
    logic rx_baud_clock_select;
    logic tx_baud_clock_select;
    logic external_trigger_enable;
    logic first_timer_run;
    logic counter_timer_select;
    logic capture_select;
  } sys_timer_two_control_t;

  // Shared control byte of the second and third timers
  typedef struct packed {
    logic third_overflow_flag;
    logic third_mode_bit;
    logic third_run_bit;
    logic third_irq_enable;
    logic second_overflow_flag;
    logic second_mode_bit;
    logic second_run_bit;
    logic second_irq_enable;
  } sys_timers_three_four_control_t;

  // Wide timer control byte
  typedef struct packed {
    logic       overflow_flag;
    logic [1:0] clock_select;
    logic       mode_bit;
    logic       run_bit;
    logic [1:0] spare;
    logic       wake_enable;
  } sys_t5con_t;

  // Wide timer clock sources
  typedef enum logic [1:0] {
    SRC_FAST = 2'h0,
    SRC_XTAL = 2'h1,
    SRC_RTC  = 2'h2,
    SRC_SLOW = 2'h3
  } sys_t5_src_t;

  // First timer modes, one-hot
  typedef enum logic [3:0] {
    FT_STOP    = 4'h1,
    FT_RELOAD  = 4'h2,
    FT_CAPTURE = 4'h4,
    FT_BAUD    = 4'h8
  } sys_ft_mode_t;

endpackage : sys_tmr_pkg

// File: verilog/sys_tmr_top.sv
// How it works
// [R1] Baud bits, capture-select, run pick first timer mode
// [R2] Reload mode: overflow sets flag, reloads count
// [R3] Capture mode: trigger fall copies count to reload
// [R4] Either baud bit set means baud generator mode
// [R5] Baud overflow pulses leave the block nowhere
// [R6] One shared pin feeds count and trigger
// [R7] Second and third timers: 16-bit, system clock
// [R8] Hardware only sets overflow flags, software clears
// [R9] Mode bit one reloads, zero runs free
// [R10] Second and third timers count only while running
// [R11] Interrupt request masked by its enable bit
// [R12] Count writes go to reload or live counter
// [R13] Count reads return the live counter
// [R14] Software reads high byte before low byte
// [R15] Wide timer clock chosen from four sources
// [R16] Wide timer free-running or auto-reload
// [R17] Wide timer ignores low-power modes, can wake
// [R18] No first timer overflow flag set in baud mode
// [R19] Counter select counts shared pin events
// [R20] Enabled trigger fall captures or reloads
// [R21] All-ones to zero is overflow, reload same cycle
//
// Added by the designer: register access over APB.
module sys_tmr_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic        count_trigger_pin,
  input  wire logic        fast_internal_oscillator,
  input  wire logic        crystal_oscillator,
  input  wire logic        rtc_clock,
  input  wire logic        slow_oscillator,
  // Requests
  output logic             first_irq,
  output logic             second_irq,
  output logic             third_irq,
  output logic             wake_request
);

  // Pin synchronisers: two flops, then a third for edge detection
  logic [4:0] pin_raw;
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [4:0] pin_s3_q;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;

  assign pin_raw = {slow_oscillator, rtc_clock, crystal_oscillator,
                    fast_internal_oscillator, count_trigger_pin};

  genvar gp;
  generate
    for (gp = 0; gp < sys_tmr_pkg::N_PINS; gp++) begin : g_sync
      // Stage one is read by stage two only
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_s1_q[gp] <= 1'b0;
          pin_s2_q[gp] <= 1'b0;
          pin_s3_q[gp] <= 1'b0;
        end else begin
          pin_s1_q[gp] <= pin_raw[gp];
          pin_s2_q[gp] <= pin_s1_q[gp];
          pin_s3_q[gp] <= pin_s2_q[gp];
        end
      end
      assign pin_rise[gp] = pin_s2_q[gp] & ~pin_s3_q[gp];
      assign pin_fall[gp] = ~pin_s2_q[gp] & pin_s3_q[gp];
    end
  endgenerate

  // APB decode; offsets are indices, so the byte address is index times four
  logic [7:0] idx;
  logic       addr_ok;
  logic       hit_t4lo, hit_t4hi, hit_t3lo, hit_t3hi, hit_timer_two_control, hit_rllo;
  logic       hit_rlhi, hit_t2lo, hit_t2hi, hit_t34, hit_t5con, hit_t5cnt;
  logic       mapped;
  logic       setup_ph;
  logic       wr_en;

  assign idx       = paddr[9:2];
  assign addr_ok   = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
  assign hit_t4lo  = addr_ok && (idx == sys_tmr_pkg::IDX_T4_LO);
  assign hit_t4hi  = addr_ok && (idx == sys_tmr_pkg::IDX_T4_HI);
  assign hit_t3lo  = addr_ok && (idx == sys_tmr_pkg::IDX_T3_LO);
  assign hit_t3hi  = addr_ok && (idx == sys_tmr_pkg::IDX_T3_HI);
  assign hit_timer_two_control = addr_ok && (idx == sys_tmr_pkg::IDX_FT_CON);
  assign hit_rllo  = addr_ok && (idx == sys_tmr_pkg::IDX_FT_RLLO);
  assign hit_rlhi  = addr_ok && (idx == sys_tmr_pkg::IDX_FT_RLHI);
  assign hit_t2lo  = addr_ok && (idx == sys_tmr_pkg::IDX_FT_LO);
  assign hit_t2hi  = addr_ok && (idx == sys_tmr_pkg::IDX_FT_HI);
  assign hit_t34   = addr_ok && (idx == sys_tmr_pkg::IDX_T34_CON);
  assign hit_t5con = addr_ok && (idx == sys_tmr_pkg::IDX_T5_CON);
  assign hit_t5cnt = addr_ok && (idx == sys_tmr_pkg::IDX_T5_CNT);
  assign mapped    = hit_t4lo | hit_t4hi | hit_t3lo | hit_t3hi | hit_timer_two_control | hit_rllo
                   | hit_rlhi | hit_t2lo | hit_t2hi | hit_t34 | hit_t5con | hit_t5cnt;
  assign setup_ph  = psel & ~penable;
  // Writes land at the single access edge; lane 0 carries every byte register
  assign wr_en     = psel & penable & pwrite & pready & mapped & pstrb[0];

  // Shared pin: count events and trigger edges see the same falling edge
  logic ext_fall;
  assign ext_fall = pin_fall[sys_tmr_pkg::PIN_SHARED]; // R6

  // ---------------- First timer ----------------
  sys_tmr_pkg::sys_timer_two_control_t   timer_two_control_q, timer_two_control_d;
  sys_tmr_pkg::sys_ft_mode_t ft_mode;
  logic [15:0] ft_cnt_q;
  logic [15:0] ft_rld_q;
  logic        ft_tick;
  logic        ft_ovf;
  logic        ft_trig;
  logic        ft_baud_tick;

  // Mode select; run low overrides every other bit
  assign ft_mode = !timer_two_control_q.first_timer_run ? sys_tmr_pkg::FT_STOP :                  // R1
                   (timer_two_control_q.rx_baud_clock_select | timer_two_control_q.tx_baud_clock_select)
                     ? sys_tmr_pkg::FT_BAUD :                                         // R4
                   timer_two_control_q.capture_select ? sys_tmr_pkg::FT_CAPTURE                   // R3
                                          : sys_tmr_pkg::FT_RELOAD;                   // R2

  // One count per clock in timer mode, one per pin fall in counter mode
  assign ft_tick = timer_two_control_q.counter_timer_select ? ext_fall : 1'b1; // R19
  assign ft_ovf  = (ft_mode != sys_tmr_pkg::FT_STOP) && ft_tick
                   && (ft_cnt_q == sys_tmr_pkg::MAX_CNT16); // R21
  // Trigger edges capture or reload only when enabled and in reload or capture mode; the edge flag needs only the enable
  assign ft_trig = ext_fall && timer_two_control_q.external_trigger_enable // R20
                   && ((ft_mode == sys_tmr_pkg::FT_RELOAD)
                    || (ft_mode == sys_tmr_pkg::FT_CAPTURE));
  // Serial clock pulses; there is no serial port here to take them
  assign ft_baud_tick = ft_ovf && (ft_mode == sys_tmr_pkg::FT_BAUD); // R5

  // Control byte: hardware sets win over a software clear in the same cycle
  always_comb begin
    timer_two_control_d = timer_two_control_q;
    if (wr_en && hit_timer_two_control) begin
      timer_two_control_d = sys_tmr_pkg::sys_timer_two_control_t'(pwdata[7:0]);
    end
    if (ft_ovf && !ft_baud_tick) begin
      timer_two_control_d.first_timer_overflow_flag = 1'b1; // R8 R18
    end
    if (ext_fall && timer_two_control_q.external_trigger_enable) begin
      timer_two_control_d.trigger_edge_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_two_control_q <= sys_tmr_pkg::sys_timer_two_control_t'(sys_tmr_pkg::RST_BYTE);
    end else begin
      timer_two_control_q <= timer_two_control_d;
    end
  end

  // Counter: software write beats counting; reload on overflow except in capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ft_cnt_q <= sys_tmr_pkg::RST_CNT;
    end else if (wr_en && hit_t2lo) begin
      ft_cnt_q[7:0] <= pwdata[7:0];
    end else if (wr_en && hit_t2hi) begin
      ft_cnt_q[15:8] <= pwdata[7:0];
    end else if (ft_ovf && (ft_mode != sys_tmr_pkg::FT_CAPTURE)) begin
      ft_cnt_q <= ft_rld_q; // R2 R4
    end else if (ft_trig && (ft_mode == sys_tmr_pkg::FT_RELOAD)) begin
      ft_cnt_q <= ft_rld_q; // R20
    end else if ((ft_mode != sys_tmr_pkg::FT_STOP) && ft_tick) begin
      ft_cnt_q <= ft_cnt_q + 16'h0001;
    end
  end

  // Reload pair doubles as the capture register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ft_rld_q <= sys_tmr_pkg::RST_CNT;
    end else if (wr_en && hit_rllo) begin
      ft_rld_q[7:0] <= pwdata[7:0];
    end else if (wr_en && hit_rlhi) begin
      ft_rld_q[15:8] <= pwdata[7:0];
    end else if (ft_trig && (ft_mode == sys_tmr_pkg::FT_CAPTURE)) begin
      ft_rld_q <= ft_cnt_q; // R3
    end
  end

  // ---------------- Second and third timers ----------------
  sys_tmr_pkg::sys_timers_three_four_control_t t34_q, t34_d;
  logic [1:0]  st_run;
  logic [1:0]  st_mode;
  logic [1:0]  st_ovf;
  logic [1:0]  st_wr_lo;
  logic [1:0]  st_wr_hi;
  logic [15:0] st_cnt_q [2];
  logic [15:0] st_rld_q [2];

  assign st_run   = {t34_q.third_run_bit,  t34_q.second_run_bit};
  assign st_mode  = {t34_q.third_mode_bit, t34_q.second_mode_bit};
  assign st_wr_lo = {wr_en & hit_t4lo, wr_en & hit_t3lo};
  assign st_wr_hi = {wr_en & hit_t4hi, wr_en & hit_t3hi};

  genvar gt;
  generate
    for (gt = 0; gt < 2; gt++) begin : g_sys
      // Overflow on the system clock tick that wraps all ones
      assign st_ovf[gt] = st_run[gt] && (st_cnt_q[gt] == sys_tmr_pkg::MAX_CNT16); // R7 R21

      // Writes steer to the reload value or the live count by mode
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_rld_q[gt] <= sys_tmr_pkg::RST_CNT;
        end else if (st_wr_lo[gt] && st_mode[gt]) begin
          st_rld_q[gt][7:0] <= pwdata[7:0]; // R12
        end else if (st_wr_hi[gt] && st_mode[gt]) begin
          st_rld_q[gt][15:8] <= pwdata[7:0]; // R12
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_cnt_q[gt] <= sys_tmr_pkg::RST_CNT;
        end else if (st_wr_lo[gt] && !st_mode[gt]) begin
          st_cnt_q[gt][7:0] <= pwdata[7:0]; // R12
        end else if (st_wr_hi[gt] && !st_mode[gt]) begin
          st_cnt_q[gt][15:8] <= pwdata[7:0]; // R12
        end else if (st_ovf[gt] && st_mode[gt]) begin
          st_cnt_q[gt] <= st_rld_q[gt]; // R9 R21
        end else if (st_run[gt]) begin
          st_cnt_q[gt] <= st_cnt_q[gt] + 16'h0001; // R9 R10
        end
      end
    end
  endgenerate

  // Shared control byte; set beats a clear written in the same cycle
  always_comb begin
    t34_d = t34_q;
    if (wr_en && hit_t34) begin
      t34_d = sys_tmr_pkg::sys_timers_three_four_control_t'(pwdata[7:0]);
    end
    if (st_ovf[0]) begin
      t34_d.second_overflow_flag = 1'b1; // R8
    end
    if (st_ovf[1]) begin
      t34_d.third_overflow_flag = 1'b1; // R8
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t34_q <= sys_tmr_pkg::sys_timers_three_four_control_t'(sys_tmr_pkg::RST_BYTE);
    end else begin
      t34_q <= t34_d;
    end
  end

  // ---------------- Wide timer ----------------
  sys_tmr_pkg::sys_t5con_t t5con_q, t5con_d;
  logic [23:0] t5_cnt_q;
  logic [23:0] t5_rld_q;
  logic        t5_tick;
  logic        t5_ovf;
  logic        t5_wr_cnt;
  logic [1:0]  t5_src;

  // Source edges are sampled on pclk, so a source must run below half of it
  assign t5_src  = t5con_q.clock_select;
  assign t5_tick = (t5_src == sys_tmr_pkg::SRC_FAST) ? pin_rise[sys_tmr_pkg::PIN_FAST]
                 : (t5_src == sys_tmr_pkg::SRC_XTAL) ? pin_rise[sys_tmr_pkg::PIN_XTAL]
                 : (t5_src == sys_tmr_pkg::SRC_RTC)  ? pin_rise[sys_tmr_pkg::PIN_RTC]
                 : pin_rise[sys_tmr_pkg::PIN_SLOW]; // R15
  assign t5_ovf    = t5con_q.run_bit && t5_tick && (t5_cnt_q == sys_tmr_pkg::MAX_CNT24);
  assign t5_wr_cnt = wr_en && hit_t5cnt;

  // No low-power input gates this timer; while run is set it counts every source rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t5_cnt_q <= sys_tmr_pkg::RST_T5;
    end else if (t5_wr_cnt && !t5con_q.mode_bit) begin
      t5_cnt_q <= pwdata[23:0];
    end else if (t5_ovf && t5con_q.mode_bit) begin
      t5_cnt_q <= t5_rld_q; // R16
    end else if (t5con_q.run_bit && t5_tick) begin
      t5_cnt_q <= t5_cnt_q + 24'h000001; // R16 R17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t5_rld_q <= sys_tmr_pkg::RST_T5;
    end else if (t5_wr_cnt && t5con_q.mode_bit) begin
      t5_rld_q <= pwdata[23:0];
    end
  end

  // Wide timer control with sticky flag; spare bits read as zero
  always_comb begin
    t5con_d = t5con_q;
    if (wr_en && hit_t5con) begin
      t5con_d = sys_tmr_pkg::sys_t5con_t'(pwdata[7:0]);
    end
    t5con_d.spare = 2'h0;
    if (t5_ovf) begin
      t5con_d.overflow_flag = 1'b1; // R8
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t5con_q <= sys_tmr_pkg::sys_t5con_t'(sys_tmr_pkg::RST_BYTE);
    end else begin
      t5con_q <= t5con_d;
    end
  end

  // ---------------- Read mux and bus answer ----------------
  logic [31:0] rd_mux;

  // Live counters, no snapshot of the other byte
  assign rd_mux = ({32{hit_t4lo}}  & {24'h0, st_cnt_q[1][7:0]})  // R13
                | ({32{hit_t4hi}}  & {24'h0, st_cnt_q[1][15:8]}) // R13 R14
                | ({32{hit_t3lo}}  & {24'h0, st_cnt_q[0][7:0]})  // R13
                | ({32{hit_t3hi}}  & {24'h0, st_cnt_q[0][15:8]}) // R13 R14
                | ({32{hit_timer_two_control}} & {24'h0, timer_two_control_q})
                | ({32{hit_rllo}}  & {24'h0, ft_rld_q[7:0]})
                | ({32{hit_rlhi}}  & {24'h0, ft_rld_q[15:8]})
                | ({32{hit_t2lo}}  & {24'h0, ft_cnt_q[7:0]})
                | ({32{hit_t2hi}}  & {24'h0, ft_cnt_q[15:8]})
                | ({32{hit_t34}}   & {24'h0, t34_q})
                | ({32{hit_t5con}} & {24'h0, t5con_q})
                | ({32{hit_t5cnt}} & {8'h0, t5_cnt_q});

  // One access cycle per transfer: ready and data are set up in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~mapped;
      prdata  <= (setup_ph && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // Request outputs, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_irq    <= 1'b0;
      second_irq   <= 1'b0;
      third_irq    <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      first_irq    <= timer_two_control_q.first_timer_overflow_flag | timer_two_control_q.trigger_edge_flag;
      second_irq   <= t34_q.second_overflow_flag & t34_q.second_irq_enable; // R11
      third_irq    <= t34_q.third_overflow_flag & t34_q.third_irq_enable;   // R11
      wake_request <= t5con_q.overflow_flag & t5con_q.wake_enable;          // R17
    end
  end

endmodule : sys_tmr_top
